// ---- lift_pkg.sv ----
// Constants and types shared by the lift station controller
// Function
// - Every discrete input is active high: one means the contact is on.
// - Fail-safe alarm inputs are normal when on; open loop raises the alarm.
// - Conditioned alarms are always one while the alarm condition is present.
// - Lead/lag pumping; lead advances to another pump whenever all pumps stop.
// - A started lag pump keeps running until level reaches the stop level.
// - Lead moves at once to the next available pump if lead becomes unavailable.
// - Each pump has a start counter and an accumulating run time.
// - With a meter, flow is its analog value; volume counts totalizer pulses.
// - Without a meter, flow is curve times running pumps; volume integrates it.
// - When armed, any door switch activation sounds the horn at once.
// - Two door switch operations within 30 seconds acknowledge the horn.
// - Failing the gesture inside the window raises the intrusion alarm.
// - After acknowledgement, entry monitoring re-arms itself after 30 minutes.
// - Supervisory master polls; the station only answers as a slave.
// - Slave address configurable: storm 10-49, domestic 50-99.
package lift_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int unsigned SEC_W = 12;
  localparam logic [SEC_W-1:0] ACK_WINDOW_S = 12'h01e;
  localparam logic [SEC_W-1:0] REARM_MIN = 12'h01e;
  localparam logic [SEC_W-1:0] REARM_S = 12'(REARM_MIN * 12'h03c);
  localparam logic [1:0] ACK_PRESSES = 2'h2;

  // ----------------------------------------------------------------
  // Station address ranges
  // ----------------------------------------------------------------
  localparam logic [7:0] STORM_ADDR_LO = 8'h0a;
  localparam logic [7:0] STORM_ADDR_HI = 8'h31;
  localparam logic [7:0] DOM_ADDR_LO = 8'h32;
  localparam logic [7:0] DOM_ADDR_HI = 8'h63;

  // ----------------------------------------------------------------
  // Poll map and status word layout
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_FLOW = 4'h1;
  localparam logic [3:0] REG_VOL_LO = 4'h2;
  localparam logic [3:0] REG_VOL_HI = 4'h3;
  localparam logic [3:0] REG_START_BASE = 4'h4;
  localparam logic [3:0] REG_RUN_BASE = 4'h8;
  localparam int unsigned ST_HORN = 0;
  localparam int unsigned ST_INTR = 1;
  localparam int unsigned ST_ARMED = 2;
  localparam int unsigned ST_HIALM = 3;
  localparam int unsigned ST_CMD = 4;
  localparam int unsigned ST_AVAIL = 8;
  localparam int unsigned ST_FAULT = 12;

  typedef enum logic [1:0] {
    ENT_ARMED,
    ENT_HORN,
    ENT_ALARM,
    ENT_DISARMED
  } entry_state_type;
endpackage : lift_pkg

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Pins and conditioned levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_type;

  sync_type s_r, s_nxt;

  // A change counts only once the second and third stages agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.q = (s_r.s2 & s_r.s3) | (s_r.q & (s_r.s2 ^ s_r.s3));
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_o = s_r.q;
endmodule : pin_sync
`default_nettype wire

// ---- lift_station_ctrl.sv ----
// Lift station pump sequencing, entry monitoring and poll answer
`timescale 1ns/10ps
`default_nettype none
module lift_station_ctrl #(
  parameter int NPUMP = 2,
  parameter int CNT_W = 16,
  parameter int TIME_W = 32,
  parameter int VOL_W = 32,
  parameter int unsigned TICK_CYCLES = lift_pkg::TICK_CYCLES,
  parameter logic [15:0] PULSE_VOL = 16'h0001
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Pump field inputs (raw pins)
  input wire logic [NPUMP-1:0] pump_running_indication_i,
  input wire logic [NPUMP-1:0] pump_auto_selector_state_i,
  input wire logic [NPUMP-1:0] pump_fault_indication_i,
  input wire logic high_level_float_i,
  input wire logic door_security_switch_i,
  input wire logic totalizer_pulse_i,
  // Analog words and configuration
  input wire logic [15:0] wet_well_level_signal_i,
  input wire logic [15:0] start_level_i,
  input wire logic [15:0] lag_start_level_i,
  input wire logic [15:0] stop_level_i,
  input wire logic meter_fitted_i,
  input wire logic [15:0] meter_flow_i,
  input wire logic [15:0] pump_curve_flow_i,
  input wire logic intrusion_clear_i,
  // Poll port
  input wire logic storm_station_i,
  input wire logic [7:0] station_addr_i,
  input wire logic poll_valid_i,
  input wire logic [7:0] poll_addr_i,
  input wire logic [3:0] poll_reg_i,
  output logic resp_valid_o,
  output logic [lift_pkg::DATA_W-1:0] resp_data_o,
  output logic addr_ok_o,
  // Pump and alarm outputs
  output logic [NPUMP-1:0] pump_run_command_o,
  output logic [NPUMP-1:0] pump_available_indication_o,
  output logic [NPUMP-1:0] pump_fault_alarm_o,
  output logic high_level_alarm_o,
  output logic [15:0] outlet_flow_rate_o,
  output logic [VOL_W-1:0] pumped_volume_total_o,
  output logic horn_o,
  output logic intrusion_alarm_o,
  output logic entry_armed_o
);
  import lift_pkg::*;

  localparam int PIDX_W = (NPUMP > 1) ? $clog2(NPUMP) : 1;
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int RAW_W = 3 * NPUMP + 3;

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [NPUMP-1:0] fault;
    logic [NPUMP-1:0] avail;
    logic [NPUMP-1:0] cmd;
    logic [NPUMP-1:0] run_prev;
    logic [PIDX_W-1:0] lead;
    logic lead_on;
    logic lag_on;
    logic [NPUMP-1:0][CNT_W-1:0] starts;
    logic [NPUMP-1:0][TIME_W-1:0] runtime;
    logic [15:0] flow;
    logic [VOL_W-1:0] volume;
    logic pulse_prev;
    logic hi_alarm;
    entry_state_type ent;
    logic [SEC_W-1:0] ent_sec;
    logic [1:0] presses;
    logic door_prev;
    logic horn;
    logic intrusion;
    logic armed;
    logic addr_ok;
    logic resp_valid;
    logic [DATA_W-1:0] resp_data;
  } state_type;

  state_type s_r, s_nxt;
  logic [RAW_W-1:0] raw_lvl;
  logic [NPUMP-1:0] run_lvl, auto_lvl, fault_lvl;
  logic hi_lvl, door_lvl, pulse_lvl;

  // Door and alarm loops idle high; reset value avoids false alarms
  pin_sync #(.W(RAW_W), .RST_VAL({{NPUMP{1'b0}}, {NPUMP{1'b0}},
      {NPUMP{1'b1}}, 3'h6})) pin_sync_i (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i({pump_running_indication_i, pump_auto_selector_state_i,
            pump_fault_indication_i, high_level_float_i,
            door_security_switch_i, totalizer_pulse_i}),
    .level_o(raw_lvl)
  );
  assign {run_lvl, auto_lvl, fault_lvl, hi_lvl, door_lvl, pulse_lvl} = raw_lvl;

  function automatic logic [PIDX_W-1:0] next_avail(
      input logic [PIDX_W-1:0] from, input logic [NPUMP-1:0] av);
    logic [PIDX_W-1:0] r;
    int idx;
    r = from;
    for (int k = NPUMP - 1; k >= 1; k--) begin
      idx = (int'(from) + k) % NPUMP;
      if (av[idx]) begin
        r = PIDX_W'(idx);
      end
    end
    return r;
  endfunction : next_avail

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NPUMP-1:0] new_cmd;
    logic [PIDX_W-1:0] lag;
    logic [15:0] flow_est;
    logic door_hit;
    logic match;
    s_nxt = s_r;
    new_cmd = '0;
    flow_est = '0;
    match = 1'b0;
    lag = '0;
    door_hit = 1'b0;
    // One-second enable
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    end
    // Fail-safe loops: open circuit is the alarm
    s_nxt.fault = ~fault_lvl;
    s_nxt.hi_alarm = ~hi_lvl;
    // Fault or not-in-auto removes a pump
    s_nxt.avail = auto_lvl & fault_lvl;
    // Level bands
    if (wet_well_level_signal_i <= stop_level_i) begin
      s_nxt.lead_on = 1'b0;
      s_nxt.lag_on = 1'b0;
    end else begin
      if (wet_well_level_signal_i >= start_level_i) begin
        s_nxt.lead_on = 1'b1;
      end
      if (wet_well_level_signal_i >= lag_start_level_i) begin
        s_nxt.lag_on = 1'b1;
      end
    end
    // Lead leaves an unavailable pump at once
    if (!s_nxt.avail[s_r.lead]) begin
      s_nxt.lead = next_avail(s_r.lead, s_nxt.avail);
    end
    lag = next_avail(s_nxt.lead, s_nxt.avail);
    for (int i = 0; i < NPUMP; i++) begin
      new_cmd[i] = s_nxt.avail[i] &
          ((s_nxt.lead_on && PIDX_W'(i) == s_nxt.lead) ||
           (s_nxt.lag_on && PIDX_W'(i) == lag && lag != s_nxt.lead));
    end
    s_nxt.cmd = new_cmd;
    // Alternate lead when every pump has stopped
    if ((|s_r.cmd) && !(|new_cmd)) begin
      s_nxt.lead = next_avail(s_nxt.lead, s_nxt.avail);
    end
    // Start counts and run time per pump
    s_nxt.run_prev = run_lvl;
    for (int i = 0; i < NPUMP; i++) begin
      if (run_lvl[i] && !s_r.run_prev[i]) begin
        s_nxt.starts[i] = s_r.starts[i] + 1'b1;
      end
      if (run_lvl[i] && s_r.tick) begin
        s_nxt.runtime[i] = s_r.runtime[i] + 1'b1;
      end
      if (run_lvl[i]) begin
        flow_est = flow_est + pump_curve_flow_i;
      end
    end
    s_nxt.pulse_prev = pulse_lvl;
    if (meter_fitted_i) begin
      s_nxt.flow = meter_flow_i;
      if (pulse_lvl && !s_r.pulse_prev) begin
        s_nxt.volume = s_r.volume + VOL_W'(PULSE_VOL);
      end
    end else begin
      s_nxt.flow = flow_est;
      if (s_r.tick) begin
        s_nxt.volume = s_r.volume + VOL_W'(flow_est);
      end
    end
    // Entry monitoring; normally-closed switch opens on activation
    s_nxt.door_prev = ~door_lvl;
    door_hit = ~door_lvl & ~s_r.door_prev;
    if (intrusion_clear_i) begin
      s_nxt.intrusion = 1'b0;
    end
    unique case (s_r.ent)
      ENT_ARMED: begin
        // Window opens at the first activation
        if (door_hit) begin
          s_nxt.ent = ENT_HORN;
          s_nxt.horn = 1'b1;
          s_nxt.ent_sec = '0;
          s_nxt.presses = 2'h1;
        end
      end
      ENT_HORN: begin
        if (door_hit) begin
          s_nxt.presses = s_r.presses + 1'b1;
        end
        if (door_hit && s_r.presses + 1'b1 >= ACK_PRESSES) begin
          s_nxt.ent = ENT_DISARMED;
          s_nxt.horn = 1'b0;
          s_nxt.ent_sec = '0;
        end else if (s_r.tick) begin
          if (s_r.ent_sec == ACK_WINDOW_S - 1'b1) begin
            s_nxt.ent = ENT_ALARM;
            s_nxt.intrusion = 1'b1;
          end else begin
            s_nxt.ent_sec = s_r.ent_sec + 1'b1;
          end
        end
      end
      ENT_ALARM: begin
        if (intrusion_clear_i) begin
          s_nxt.ent = ENT_ARMED;
          s_nxt.horn = 1'b0;
        end
      end
      ENT_DISARMED: begin
        if (s_r.tick) begin
          if (s_r.ent_sec == REARM_S - 1'b1) begin
            s_nxt.ent = ENT_ARMED;
            s_nxt.intrusion = 1'b0;
          end else begin
            s_nxt.ent_sec = s_r.ent_sec + 1'b1;
          end
        end
      end
    endcase
    s_nxt.armed = (s_nxt.ent == ENT_ARMED);
    // Address legal for the station type
    s_nxt.addr_ok = storm_station_i ?
        (station_addr_i >= STORM_ADDR_LO && station_addr_i <= STORM_ADDR_HI) :
        (station_addr_i >= DOM_ADDR_LO && station_addr_i <= DOM_ADDR_HI);
    // Answer only a poll addressed here
    match = poll_valid_i && s_r.addr_ok && poll_addr_i == station_addr_i;
    s_nxt.resp_valid = match;
    if (match) begin
      s_nxt.resp_data = '0;
      if (poll_reg_i == REG_STATUS) begin
        s_nxt.resp_data[ST_HORN] = s_r.horn;
        s_nxt.resp_data[ST_INTR] = s_r.intrusion;
        s_nxt.resp_data[ST_ARMED] = (s_r.ent == ENT_ARMED);
        s_nxt.resp_data[ST_HIALM] = s_r.hi_alarm;
        s_nxt.resp_data[ST_CMD +: NPUMP] = s_r.cmd;
        s_nxt.resp_data[ST_AVAIL +: NPUMP] = s_r.avail;
        s_nxt.resp_data[ST_FAULT +: NPUMP] = s_r.fault;
      end else if (poll_reg_i == REG_FLOW) begin
        s_nxt.resp_data = s_r.flow;
      end else if (poll_reg_i == REG_VOL_LO) begin
        s_nxt.resp_data = s_r.volume[DATA_W-1:0];
      end else if (poll_reg_i == REG_VOL_HI) begin
        s_nxt.resp_data = DATA_W'(s_r.volume >> DATA_W);
      end else begin
        for (int i = 0; i < NPUMP; i++) begin
          if (poll_reg_i == REG_START_BASE + 4'(i)) begin
            s_nxt.resp_data = DATA_W'(s_r.starts[i]);
          end
          if (poll_reg_i == REG_RUN_BASE + 4'(i)) begin
            s_nxt.resp_data = DATA_W'(s_r.runtime[i]);
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      // Monitoring is armed from power-up
      s_r.armed <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pump_run_command_o = s_r.cmd;
  assign pump_available_indication_o = s_r.avail;
  assign pump_fault_alarm_o = s_r.fault;
  assign high_level_alarm_o = s_r.hi_alarm;
  assign outlet_flow_rate_o = s_r.flow;
  assign pumped_volume_total_o = s_r.volume;
  assign horn_o = s_r.horn;
  assign intrusion_alarm_o = s_r.intrusion;
  assign entry_armed_o = s_r.armed;
  assign resp_valid_o = s_r.resp_valid;
  assign resp_data_o = s_r.resp_data;
  assign addr_ok_o = s_r.addr_ok;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unavail_idle;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (pump_fault_alarm_o != '0) |->
          ((pump_run_command_o & pump_fault_alarm_o) == '0);
  endproperty
  a_unavail_idle: assert property (p_unavail_idle)
    else $error("Faulted pump commanded to run");

  property p_fault_pol;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      $fell(fault_lvl[NPUMP-1]) |=> pump_fault_alarm_o[NPUMP-1];
  endproperty
  a_fault_pol: assert property (p_fault_pol)
    else $error("Open fault loop not flagged");

  property p_horn_on;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (s_r.ent == ENT_ARMED && !door_lvl && !s_r.door_prev) |=> horn_o;
  endproperty
  a_horn_on: assert property (p_horn_on)
    else $error("Horn not sounded on door activation");

  property p_ack;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (s_r.ent == ENT_HORN && s_r.presses == 2'h1 &&
          !door_lvl && !s_r.door_prev)
      |=> (!horn_o && s_r.ent == ENT_DISARMED);
  endproperty
  a_ack: assert property (p_ack)
    else $error("Second door operation did not silence horn");

  property p_intr_time;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      $rose(intrusion_alarm_o) |-> ($past(s_r.ent) == ENT_HORN &&
          $past(s_r.ent_sec) == ACK_WINDOW_S - 1'b1);
  endproperty
  a_intr_time: assert property (p_intr_time)
    else $error("Intrusion raised outside window expiry");

  property p_intr_latch;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (intrusion_alarm_o && !intrusion_clear_i && s_r.ent == ENT_ALARM)
      |=> intrusion_alarm_o;
  endproperty
  a_intr_latch: assert property (p_intr_latch)
    else $error("Intrusion alarm dropped without clear");

  property p_rearm;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (s_r.ent == ENT_DISARMED && s_r.tick && s_r.ent_sec == REARM_S - 1'b1)
      |=> entry_armed_o;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("Entry monitoring did not re-arm");

  property p_lag_hold;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (s_r.lag_on && wet_well_level_signal_i > stop_level_i) |=> s_r.lag_on;
  endproperty
  a_lag_hold: assert property (p_lag_hold)
    else $error("Lag demand dropped above stop level");

  property p_start_cnt;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (run_lvl[0] && !s_r.run_prev[0]) |=>
          s_r.starts[0] == $past(s_r.starts[0]) + 1'b1;
  endproperty
  a_start_cnt: assert property (p_start_cnt)
    else $error("Start counter missed a start");

  property p_slave_only;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      resp_valid_o |-> ($past(poll_valid_i) && $past(addr_ok_o) &&
          $past(poll_addr_i) == $past(station_addr_i));
  endproperty
  a_slave_only: assert property (p_slave_only)
    else $error("Answer without a matching poll");

  property p_lead_move;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (s_r.avail != '0) |-> s_r.avail[s_r.lead];
  endproperty
  a_lead_move: assert property (p_lead_move)
    else $error("Lead stayed on unavailable pump");
endmodule : lift_station_ctrl
`default_nettype wire

// ---- poll_master.sv ----
// Supervisory poll master model for the station poll port
`timescale 1ns/10ps
`default_nettype none
module poll_master (
  // Clock
  input wire logic ref_clk_i,
  // Poll request
  output logic poll_valid_o,
  output logic [7:0] poll_addr_o,
  output logic [3:0] poll_reg_o,
  // Answer
  input wire logic resp_valid_i,
  input wire logic [15:0] resp_data_i
);
  initial begin
    poll_valid_o = 1'b0;
    poll_addr_o = 8'h00;
    poll_reg_o = 4'h0;
  end

  task poll(input logic [7:0] addr, input logic [3:0] idx,
            output logic got, output logic [15:0] data);
    @(posedge ref_clk_i);
    poll_valid_o <= 1'b1;
    poll_addr_o <= addr;
    poll_reg_o <= idx;
    @(posedge ref_clk_i);
    poll_valid_o <= 1'b0;
    // Released lines must not keep the old address
    poll_addr_o <= ~addr;
    poll_reg_o <= ~idx;
    @(posedge ref_clk_i);
    got = resp_valid_i;
    data = resp_data_i;
  endtask : poll
endmodule : poll_master
`default_nettype wire

// ---- test_lift_station_pump_and_entry_control.sv ----
// Self-checking bench for the lift station controller
`timescale 1ns/10ps
`default_nettype none
module test_lift_station_pump_and_entry_control;
  import lift_pkg::*;
  localparam int TK = 10;
  typedef struct {
    logic s;
    logic [7:0] sa;
    logic [7:0] pa;
    logic ok;
    logic ans;
  } row_type;
  row_type rows [9] = '{
    '{1'b1, 8'h0a, 8'h0a, 1'b1, 1'b1},
    '{1'b1, 8'h31, 8'h31, 1'b1, 1'b1},
    '{1'b1, 8'h09, 8'h09, 1'b0, 1'b0},
    '{1'b1, 8'h32, 8'h32, 1'b0, 1'b0},
    '{1'b0, 8'h32, 8'h32, 1'b1, 1'b1},
    '{1'b0, 8'h63, 8'h63, 1'b1, 1'b1},
    '{1'b0, 8'h64, 8'h64, 1'b0, 1'b0},
    '{1'b0, 8'h31, 8'h31, 1'b0, 1'b0},
    '{1'b0, 8'h40, 8'h41, 1'b1, 1'b0}
  };
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] run_ind = 2'b00;
  logic [1:0] auto_sel = 2'b11;
  logic [1:0] fault_pin = 2'b11;
  logic hi_float = 1'b1;
  logic door = 1'b1;
  logic tot_pulse = 1'b0;
  logic [15:0] level = 16'h0000;
  logic meter = 1'b0;
  logic [15:0] mflow = 16'h0000;
  logic clr = 1'b0;
  logic storm = 1'b1;
  logic [7:0] st_addr = 8'h0a;
  logic poll_valid;
  logic [7:0] poll_addr;
  logic [3:0] poll_reg;
  logic resp_valid, addr_ok, hi_alm, horn, intr, armed, got;
  logic [15:0] resp_data, flow, d;
  logic [1:0] cmd, avail, falm, first;
  logic [31:0] vol, v0;
  int err_count = 0;
  int checks = 0;
  int sc [2] = '{0, 0};

  // ------
  // Clock, pump and master models
  // ------
  always #2 ref_clk_i = ~ref_clk_i;

  // Pumps report running one cycle after command
  always @(posedge ref_clk_i) begin
    run_ind <= cmd;
    for (int i = 0; i < 2; i++) begin
      if (cmd[i] && !run_ind[i]) begin
        sc[i]++;
      end
    end
  end

  poll_master poll_master_i (
    .ref_clk_i(ref_clk_i),
    .poll_valid_o(poll_valid),
    .poll_addr_o(poll_addr),
    .poll_reg_o(poll_reg),
    .resp_valid_i(resp_valid),
    .resp_data_i(resp_data)
  );

  lift_station_ctrl #(.NPUMP(2), .TICK_CYCLES(TK)) lift_station_ctrl_i (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pump_running_indication_i(run_ind),
    .pump_auto_selector_state_i(auto_sel),
    .pump_fault_indication_i(fault_pin),
    .high_level_float_i(hi_float),
    .door_security_switch_i(door),
    .totalizer_pulse_i(tot_pulse),
    .wet_well_level_signal_i(level),
    .start_level_i(16'h0032),
    .lag_start_level_i(16'h0050),
    .stop_level_i(16'h000a),
    .meter_fitted_i(meter),
    .meter_flow_i(mflow),
    .pump_curve_flow_i(16'h0064),
    .intrusion_clear_i(clr),
    .storm_station_i(storm),
    .station_addr_i(st_addr),
    .poll_valid_i(poll_valid),
    .poll_addr_i(poll_addr),
    .poll_reg_i(poll_reg),
    .resp_valid_o(resp_valid),
    .resp_data_o(resp_data),
    .addr_ok_o(addr_ok),
    .pump_run_command_o(cmd),
    .pump_available_indication_o(avail),
    .pump_fault_alarm_o(falm),
    .high_level_alarm_o(hi_alm),
    .outlet_flow_rate_o(flow),
    .pumped_volume_total_o(vol),
    .horn_o(horn),
    .intrusion_alarm_o(intr),
    .entry_armed_o(armed)
  );

  // ------
  // Helpers
  // ------
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick

  task check(input logic [31:0] g, input logic [31:0] e, input string msg);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task finish_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task ask(input logic [3:0] idx, input logic [15:0] e, input string msg);
    poll_master_i.poll(st_addr, idx, got, d);
    if (got !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: no answer", $time);
    end
    check(d, e, msg);
  endtask : ask

  // Hang guard
  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  // ------
  // Sequence
  // ------
  initial begin
    tick(10);
    check({armed, horn, cmd}, 4'h8, "reset outputs");
    tick(10);
    rstn_i <= 1'b1;
    tick(8);
    ask(REG_STATUS, 16'h0304, "idle status");
    ask(4'hf, 16'h0000, "unmapped index");
    foreach (rows[i]) begin
      storm <= rows[i].s;
      st_addr <= rows[i].sa;
      tick(2);
      check(addr_ok, rows[i].ok, "address range");
      poll_master_i.poll(rows[i].pa, REG_STATUS, got, d);
      check(got, rows[i].ans, "answer or refusal");
    end
    storm <= 1'b1;
    st_addr <= 8'h0a;
    level <= 16'h003c;
    tick(8);
    first = cmd;
    check(cmd[0] ^ cmd[1], 1'b1, "one lead");
    level <= 16'h005a;
    tick(12);
    check(cmd, 2'b11, "lag on");
    check(flow, 16'h00c8, "curve flow");
    ask(REG_FLOW, 16'h00c8, "polled flow");
    level <= 16'h0028;
    tick(8);
    check(cmd, 2'b11, "lag held");
    level <= 16'h0005;
    tick(8);
    check(cmd, 2'b00, "all stop");
    level <= 16'h003c;
    tick(8);
    check(cmd, 2'(~first), "lead alternates");
    fault_pin <= first;
    tick(8);
    check({cmd, falm, avail}, {first, ~first, first}, "fault");
    fault_pin <= 2'b11;
    auto_sel <= ~first;
    tick(8);
    check(cmd, 2'(~first), "not auto");
    auto_sel <= 2'b11;
    level <= 16'h0005;
    tick(8);
    ask(REG_START_BASE, 16'(sc[0]), "starts 0");
    ask(REG_START_BASE + 4'h1, 16'(sc[1]), "starts 1");
    poll_master_i.poll(st_addr, REG_RUN_BASE, got, d);
    check(32'(d != 16'h0000), 32'h1, "run time");
    meter <= 1'b1;
    mflow <= 16'h04d2;
    tick(8);
    check(flow, 16'h04d2, "meter flow");
    v0 = vol;
    repeat (3) begin
      tot_pulse <= 1'b1;
      tick(8);
      tot_pulse <= 1'b0;
      tick(8);
    end
    check(vol, v0 + 32'h3, "pulse volume");
    ask(REG_VOL_LO, 16'(v0 + 32'h3), "volume low");
    ask(REG_VOL_HI, 16'((v0 + 32'h3) >> 16), "volume high");
    hi_float <= 1'b0;
    tick(8);
    check(hi_alm, 1'b1, "high level");
    ask(REG_STATUS, 16'h030c, "alarm status");
    hi_float <= 1'b1;
    door <= 1'b0;
    tick(8);
    check(horn, 1'b1, "horn on entry");
    door <= 1'b1;
    tick(8);
    door <= 1'b0;
    tick(8);
    check({horn, armed}, 2'b00, "acknowledged");
    door <= 1'b1;
    tick(1790 * TK);
    check(armed, 1'b0, "still disarmed");
    tick(20 * TK);
    check(armed, 1'b1, "re-armed");
    door <= 1'b0;
    tick(8);
    door <= 1'b1;
    tick(28 * TK);
    check(intr, 1'b0, "window open");
    tick(4 * TK);
    check({horn, intr}, 2'b11, "intrusion");
    clr <= 1'b1;
    tick(8);
    clr <= 1'b0;
    tick(8);
    check({horn, intr, armed}, 3'h1, "cleared");
    finish_test();
  end
endmodule : test_lift_station_pump_and_entry_control
`default_nettype wire
